// ==== usbrs_pkg.sv ====
// Constants, timing counts and state codes for the USB bus monitor and
// re-timer. Assumes a single 40 MHz core clock.
`default_nettype none

package usbrs_pkg;

    // Core clock period
    localparam int CLK_PERIOD_NS = 25;

    // State timeouts in microseconds, as specified
    localparam int T_INIT_US   = 10_000;
    localparam int T_DETACH_US = 3_000;
    localparam int T_SE0_US    = 3_000;

    // Least times, rounded up to whole clock cycles
    localparam int INIT_CYC   = (T_INIT_US * 1000 + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
    localparam int DETACH_CYC = (T_DETACH_US * 1000 + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
    localparam int SE0_CYC    = (T_SE0_US * 1000 + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;

    // Width of the timers; holds the longest count above
    localparam int TMR_W = 20;

    // Regenerated SYNC, sent as bytes least significant bit first
    localparam int SYNC_BITS  = 32;
    localparam int SYNC_BYTES = SYNC_BITS / 8;
    localparam logic [7:0] SYNC_BYTE_FILL = 8'h00;
    localparam logic [7:0] SYNC_BYTE_END  = 8'h80;

    // Longest receive to transmit delay, in bit times and in byte slots
    localparam int MAX_DLY_SYNC32_BITS = 40;
    localparam int MAX_DLY_SYNC12_BITS = 60;
    localparam int MAX_DLY_SYNC32_CYC  = MAX_DLY_SYNC32_BITS / 8;
    localparam int MAX_DLY_SYNC12_CYC  = MAX_DLY_SYNC12_BITS / 8;

    // Packet buffer shape
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W     = 10;

    // Bus monitor states
    typedef enum logic [5:0] {
        ST_RESET  = 6'h01,
        ST_INIT   = 6'h02,
        ST_DISC   = 6'h04,
        ST_FSLS   = 6'h08,
        ST_HS     = 6'h10,
        ST_DETACH = 6'h20
    } usbrs_state_t;

    // Re-timer transmit states
    typedef enum logic [2:0] {
        TX_IDLE = 3'h1,
        TX_SYNC = 3'h2,
        TX_DATA = 3'h4
    } usbrs_tx_t;

endpackage

`default_nettype wire

// ==== usbrs_fifo.sv ====
// Packet byte buffer between the receive and transmit side of the re-timer.
// Assumes DEPTH is a power of two; read data come from a register.
`default_nettype none

module usbrs_fifo #(
    parameter int W     = 10,
    parameter int DEPTH = 16
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_wr_valid,
    input  wire logic [W-1:0] i_wr_data,
    output logic              o_wr_ready,
    output logic              o_rd_valid,
    output logic [W-1:0]      o_rd_data,
    input  wire logic         i_rd_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic          do_wr;
    logic          do_ld;

    assign o_wr_ready = cnt_q != (AW+1)'(DEPTH);
    assign do_wr      = i_wr_valid && o_wr_ready;
    // Output stage refills whenever it is empty or being drained
    assign do_ld      = (cnt_q != '0) && (!o_rd_valid || i_rd_ready);

    always_ff @(posedge i_core_clk) begin
        if (do_wr) begin
            mem_q[wp_q] <= i_wr_data;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_wr) begin
                wp_q <= wp_q + 1'b1;
            end
            if (do_ld) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_ld);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_valid <= 1'b0;
            o_rd_data  <= '0;
        end else if (do_ld) begin
            o_rd_valid <= 1'b1;
            o_rd_data  <= mem_q[rp_q];
        end else if (i_rd_ready) begin
            o_rd_valid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ==== usbrs_monitor.sv ====
// Bus monitor state machine and high-speed packet re-timer of a two-port
// USB 2.0 repeater. Assumes all inputs synchronous to i_core_clk except
// i_conn_en, and a byte-wide packet interface to the line front ends.
`default_nettype none

module usbrs_monitor #(
    parameter int                              FIFO_DEPTH = 16,
    parameter logic [usbrs_pkg::TMR_W-1:0] INIT_CYC   =
        usbrs_pkg::TMR_W'(usbrs_pkg::INIT_CYC),
    parameter logic [usbrs_pkg::TMR_W-1:0] DETACH_CYC =
        usbrs_pkg::TMR_W'(usbrs_pkg::DETACH_CYC),
    parameter logic [usbrs_pkg::TMR_W-1:0] SE0_CYC    =
        usbrs_pkg::TMR_W'(usbrs_pkg::SE0_CYC)
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_conn_en,
    input  wire logic       i_detach_strap,
    input  wire logic       i_hs_handshake_done,
    input  wire logic       i_hs_resume_done,
    input  wire logic       i_sof_level_rise,
    input  wire logic       i_se0_int,
    input  wire logic       i_se0_ext,
    input  wire logic       i_rx_valid,
    input  wire logic [7:0] i_rx_data,
    input  wire logic       i_rx_last,
    input  wire logic       i_rx_from_ext,
    output logic            o_rx_ready,
    input  wire logic       i_tx_ready,
    output logic            o_tx_valid,
    output logic [7:0]      o_tx_data,
    output logic            o_tx_last,
    output logic            o_tx_to_ext,
    output logic            o_switch_on,
    output logic            o_bc_only,
    output logic            o_retimer_on,
    output logic [5:0]      o_state
);
    localparam int TW   = usbrs_pkg::TMR_W;
    localparam int FW   = usbrs_pkg::FIFO_W;
    localparam int MD32 = usbrs_pkg::MAX_DLY_SYNC32_CYC;
    localparam int MD12 = usbrs_pkg::MAX_DLY_SYNC12_CYC;
    localparam logic [1:0] SYNC_LAST = 2'(usbrs_pkg::SYNC_BYTES - 1);

    usbrs_pkg::usbrs_state_t st_q;
    usbrs_pkg::usbrs_state_t st_d;
    usbrs_pkg::usbrs_tx_t    tx_q;

    logic          en_meta_q;
    logic          en_q;
    logic          strap_q;
    logic [TW-1:0] tmr_q;
    logic          tmr_init_done;
    logic          tmr_det_done;
    logic [1:0]    se0_in;
    logic [1:0]    se0_hit;
    logic [1:0]    sync_cnt_q;
    logic          fifo_wr_valid;
    logic          fifo_wr_ready;
    logic          fifo_rd_valid;
    logic [FW-1:0] fifo_rd_data;
    logic          fifo_rd_ready;
    logic          tx_adv;

    // Two-flop synchroniser; only en_q feeds the state machine
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_meta_q <= 1'b0;
            en_q      <= 1'b0;
        end else begin
            en_meta_q <= i_conn_en;
            en_q      <= en_meta_q;
        end
    end

    // Strap is caught at the first edge after reset release
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strap_q <= 1'b0;
        end else if (st_q == usbrs_pkg::ST_RESET) begin
            strap_q <= i_detach_strap;
        end
    end

    // One timer shared by the initial and detach states
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tmr_q <= '0;
        end else if (st_d != st_q) begin
            tmr_q <= '0;
        end else if (tmr_q != '1) begin
            tmr_q <= tmr_q + 1'b1;
        end
    end

    assign tmr_init_done = tmr_q == INIT_CYC - 1'b1;
    assign tmr_det_done  = tmr_q == DETACH_CYC - 1'b1;

    // Per-port idle detectors; each counts from the last bus activity
    assign se0_in = {i_se0_ext, i_se0_int};

    for (genvar p = 0; p < 2; p++) begin : g_se0
        logic [TW-1:0] cnt_q;
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                cnt_q <= '0;
            end else if (!se0_in[p] || st_q != usbrs_pkg::ST_HS) begin
                cnt_q <= '0;
            end else if (cnt_q != '1) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
        assign se0_hit[p] = se0_in[p] && (cnt_q == SE0_CYC - 1'b1);
    end

    // Next state; outside the reset and initial states a dropped enable wins over every other event
    always_comb begin
        st_d = st_q;
        case (st_q)
            usbrs_pkg::ST_RESET: begin
                st_d = usbrs_pkg::ST_INIT;
            end
            usbrs_pkg::ST_INIT: begin
                if (tmr_init_done) begin
                    st_d = usbrs_pkg::ST_DISC;
                end
            end
            usbrs_pkg::ST_DISC: begin
                if (en_q) begin
                    st_d = usbrs_pkg::ST_FSLS;
                end
            end
            usbrs_pkg::ST_FSLS: begin
                if (!en_q) begin
                    st_d = usbrs_pkg::ST_DISC;
                end else if (i_hs_handshake_done || i_hs_resume_done) begin
                    st_d = usbrs_pkg::ST_HS;
                end
            end
            usbrs_pkg::ST_HS: begin
                if (!en_q) begin
                    st_d = usbrs_pkg::ST_DISC;
                end else if (i_sof_level_rise) begin
                    st_d = strap_q ? usbrs_pkg::ST_DETACH
                                   : usbrs_pkg::ST_FSLS;
                end else if (|se0_hit) begin
                    st_d = usbrs_pkg::ST_FSLS;
                end
            end
            usbrs_pkg::ST_DETACH: begin
                if (!en_q) begin
                    st_d = usbrs_pkg::ST_DISC;
                end else if (tmr_det_done) begin
                    st_d = usbrs_pkg::ST_FSLS;
                end
            end
            default: begin
                st_d = usbrs_pkg::ST_RESET;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= usbrs_pkg::ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // Path controls follow the next state so they change with it
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_switch_on  <= 1'b0;
            o_bc_only    <= 1'b0;
            o_retimer_on <= 1'b0;
        end else begin
            o_switch_on  <= st_d == usbrs_pkg::ST_INIT  ||
                            st_d == usbrs_pkg::ST_DISC  ||
                            st_d == usbrs_pkg::ST_FSLS;
            o_bc_only    <= st_d == usbrs_pkg::ST_INIT;
            o_retimer_on <= st_d == usbrs_pkg::ST_HS;
        end
    end

    assign o_state = st_q;

    // Receive side only takes bytes while the re-timer runs
    assign fifo_wr_valid = i_rx_valid && o_retimer_on;
    assign o_rx_ready    = fifo_wr_ready && o_retimer_on;

    usbrs_fifo #(
        .W     (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_wr_valid (fifo_wr_valid),
        .i_wr_data  ({i_rx_from_ext, i_rx_last, i_rx_data}),
        .o_wr_ready (fifo_wr_ready),
        .o_rd_valid (fifo_rd_valid),
        .o_rd_data  (fifo_rd_data),
        .i_rd_ready (fifo_rd_ready)
    );

    // Output register can take a byte when empty or being accepted
    assign tx_adv = !o_tx_valid || i_tx_ready;
    // Stale bytes are flushed while the re-timer is off
    assign fifo_rd_ready = !o_retimer_on ||
                           (tx_q == usbrs_pkg::TX_DATA && tx_adv);

    // Transmit sequencer. A buffer underrun mid-packet drops valid for a
    // slot; the line side must treat that as an aborted packet.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_q        <= usbrs_pkg::TX_IDLE;
            sync_cnt_q  <= '0;
            o_tx_valid  <= 1'b0;
            o_tx_data   <= '0;
            o_tx_last   <= 1'b0;
            o_tx_to_ext <= 1'b0;
        end else if (st_d != usbrs_pkg::ST_HS) begin
            // Cleared on the leaving edge so no byte outlives the state
            tx_q       <= usbrs_pkg::TX_IDLE;
            o_tx_valid <= 1'b0;
            o_tx_last  <= 1'b0;
        end else if (tx_adv) begin
            case (tx_q)
                usbrs_pkg::TX_IDLE: begin
                    o_tx_valid <= 1'b0;
                    o_tx_last  <= 1'b0;
                    if (fifo_rd_valid) begin
                        tx_q        <= usbrs_pkg::TX_SYNC;
                        sync_cnt_q  <= '0;
                        o_tx_to_ext <= !fifo_rd_data[FW-1];
                    end
                end
                usbrs_pkg::TX_SYNC: begin
                    o_tx_valid <= 1'b1;
                    o_tx_last  <= 1'b0;
                    o_tx_data  <= (sync_cnt_q == SYNC_LAST) ?
                                  usbrs_pkg::SYNC_BYTE_END :
                                  usbrs_pkg::SYNC_BYTE_FILL;
                    sync_cnt_q <= sync_cnt_q + 1'b1;
                    if (sync_cnt_q == SYNC_LAST) begin
                        tx_q <= usbrs_pkg::TX_DATA;
                    end
                end
                usbrs_pkg::TX_DATA: begin
                    o_tx_valid <= fifo_rd_valid;
                    o_tx_data  <= fifo_rd_data[7:0];
                    o_tx_last  <= fifo_rd_valid && fifo_rd_data[8];
                    if (fifo_rd_valid && fifo_rd_data[8]) begin
                        tx_q <= usbrs_pkg::TX_IDLE;
                    end
                end
                default: begin
                    tx_q       <= usbrs_pkg::TX_IDLE;
                    o_tx_valid <= 1'b0;
                end
            endcase
        end
    end

    // Checks on the state machine and the re-timer

    a_reset_path_off: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(i_rst_n) || st_q == usbrs_pkg::ST_RESET
            |-> !o_switch_on && !o_retimer_on)
        else $error("Path active in reset state");

    a_init_bc_only: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        st_q == usbrs_pkg::ST_INIT |-> o_switch_on && o_bc_only)
        else $error("Initial state not in charge-only pass");

    a_init_length: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        st_q == usbrs_pkg::ST_INIT && tmr_q == INIT_CYC - 1'b1
            |=> st_q == usbrs_pkg::ST_DISC)
        else $error("Initial interval not ended on time");

    a_disc_to_pass: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        st_q == usbrs_pkg::ST_DISC && en_q
            |=> st_q == usbrs_pkg::ST_FSLS && o_switch_on)
        else $error("Enable did not open pass-through");

    a_hs_entry: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        st_q == usbrs_pkg::ST_FSLS && en_q && i_hs_resume_done
            |=> st_q == usbrs_pkg::ST_HS && !o_switch_on && o_retimer_on)
        else $error("High speed entry wrong");

    a_detach_strap0: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        st_q == usbrs_pkg::ST_HS && en_q && i_sof_level_rise && !strap_q
            |=> st_q == usbrs_pkg::ST_FSLS && o_switch_on && !o_retimer_on)
        else $error("Detach without strap not to pass-through");

    a_detach_strap1: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        st_q == usbrs_pkg::ST_HS && en_q && i_sof_level_rise && strap_q
            |=> st_q == usbrs_pkg::ST_DETACH && !o_switch_on
                && !o_retimer_on)
        else $error("Detach with strap wrong");

    a_enable_drop: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !en_q && (st_q == usbrs_pkg::ST_FSLS || st_q == usbrs_pkg::ST_HS
                  || st_q == usbrs_pkg::ST_DETACH)
            |=> st_q == usbrs_pkg::ST_DISC)
        else $error("Enable low did not disconnect");

    a_timer_restart: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        st_q != $past(st_q) |-> tmr_q == '0)
        else $error("Timer not restarted on state entry");

    a_tx_only_hs: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_tx_valid |-> st_q == usbrs_pkg::ST_HS)
        else $error("Transmit outside high speed");

    a_sync_full: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        tx_q == usbrs_pkg::TX_SYNC && st_d == usbrs_pkg::ST_HS && tx_adv
            && sync_cnt_q == SYNC_LAST
            |=> o_tx_valid && o_tx_data == usbrs_pkg::SYNC_BYTE_END
                && tx_q == usbrs_pkg::TX_DATA)
        else $error("SYNC not ended after full length");

    a_retime_delay: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        fifo_wr_valid && fifo_wr_ready && tx_q == usbrs_pkg::TX_IDLE
            && !fifo_rd_valid && !o_tx_valid && i_tx_ready
            && st_d == usbrs_pkg::ST_HS
            |-> ##[1:MD32] (o_tx_valid || st_q != usbrs_pkg::ST_HS))
        else $error("Re-timer delay too long");

    a_se0_exit: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        st_q == usbrs_pkg::ST_HS && en_q && !i_sof_level_rise && |se0_hit
            |=> st_q == usbrs_pkg::ST_FSLS && o_switch_on && !o_retimer_on)
        else $error("Idle line did not leave high speed");

endmodule

`default_nettype wire

// ==== usbrs_line_model.sv ====
// Far-side line model: the USB party that takes re-timed bytes.
// Assumes the byte-wide transmit handshake runs on the core clock.
`default_nettype none

module usbrs_line_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_stall,
    input  wire logic       i_slow,
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    input  wire logic       i_tx_last,
    input  wire logic       i_tx_to_ext,
    output logic            o_tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] got_q[$];
    realtime    at_q[$];
    logic       tog_q = 1'b0;

    // Slow mode is ready on every other cycle, like a congested port
    always @(posedge i_core_clk) begin
        tog_q <= ~tog_q;
        if (i_tx_valid && o_tx_ready) begin
            got_q.push_back({i_tx_last, i_tx_to_ext, i_tx_data});
            at_q.push_back($realtime);
        end
    end

    assign o_tx_ready = ~i_stall & (~i_slow | tog_q);
endmodule

`default_nettype wire

// ==== usbrs_monitor_tb.sv ====
// Self-checking bench for the bus monitor and packet re-timer.
// Assumes the package, buffer, monitor and line model are compiled first.
`default_nettype none

module usbrs_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // Short timeouts keep the run brief; the checked state lengths derive from these
    localparam int INIT  = 40;
    localparam int DET   = 20;
    localparam int SE0   = 20;
    localparam int DEPTH = usbrs_pkg::FIFO_DEPTH;
    localparam int LIMIT = 5000;
    logic       clk, rst_n, en, strap, se0i, se0e, rxv, rxl, rxe;
    logic       stall, slow, rx_rdy, txv, txl, txe, txr, sw, bc, rt;
    logic [2:0] evt;
    logic [7:0] rxd, txd;
    logic [5:0] st;
    int         mismatches = 0;
    int         n_checks = 0;
    int         taken = 0;
    int         cyc = 0;
    realtime    t_first;

    usbrs_monitor #(
        .FIFO_DEPTH (DEPTH),
        .INIT_CYC   (usbrs_pkg::TMR_W'(INIT)),
        .DETACH_CYC (usbrs_pkg::TMR_W'(DET)),
        .SE0_CYC    (usbrs_pkg::TMR_W'(SE0))
    ) u_usbrs_monitor (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_conn_en(en),
        .i_detach_strap(strap), .i_hs_handshake_done(evt[0]),
        .i_hs_resume_done(evt[1]), .i_sof_level_rise(evt[2]),
        .i_se0_int(se0i), .i_se0_ext(se0e), .i_rx_valid(rxv),
        .i_rx_data(rxd), .i_rx_last(rxl), .i_rx_from_ext(rxe),
        .o_rx_ready(rx_rdy), .i_tx_ready(txr), .o_tx_valid(txv),
        .o_tx_data(txd), .o_tx_last(txl), .o_tx_to_ext(txe),
        .o_switch_on(sw), .o_bc_only(bc), .o_retimer_on(rt), .o_state(st)
    );

    usbrs_line_model u_usbrs_line_model (
        .i_core_clk(clk), .i_stall(stall), .i_slow(slow), .i_tx_valid(txv),
        .i_tx_data(txd), .i_tx_last(txl), .i_tx_to_ext(txe),
        .o_tx_ready(txr)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic final_report;
        $display("Checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A hang would otherwise stall the run forever
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            mismatches++;
            $display("ERROR timeout expected %0d seen %0d", LIMIT, cyc);
            final_report();
        end
    end

    task automatic chk(input string what, input logic [9:0] e,
                       input logic [9:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_path(input logic [5:0] s, input logic w,
                            input logic r);
        chk("state", 10'(s), 10'(st));
        chk("switch", 10'(w), 10'(sw));
        chk("retimer", 10'(r), 10'(rt));
    endtask

    task automatic wait_leave(input logic [5:0] s, output int n);
        n = 0;
        while (st === s && n < 1000) begin
            n++;
            @(negedge clk);
        end
    endtask

    task automatic ev(input int k);
        @(posedge clk);
        evt[k] <= 1'b1;
        @(posedge clk);
        evt <= 3'h0;
        @(negedge clk);
    endtask

    // Bytes stand until the edge that samples ready high
    task automatic send_pkt(input int n, input logic x, input logic [7:0] b);
        @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rxv <= 1'b1;
            rxd <= b + 8'(i);
            rxl <= (i == n - 1);
            rxe <= x;
            do @(posedge clk); while (rx_rdy !== 1'b1);
            taken++;
            if (i == 0) t_first = $realtime;
        end
        rxv <= 1'b0;
    endtask

    task automatic chk_pkt(input int n, input logic x, input logic [7:0] b,
                           input logic lat);
        logic [9:0] e;
        int         k;
        k = 0;
        while (u_usbrs_line_model.got_q.size() < n + 4 && k < 400) begin
            k++;
            @(negedge clk);
        end
        for (int j = 0; j < n + 4; j++) begin
            e[7:0] = (j < 3) ? 8'h00 : (j == 3) ? 8'h80 : b + 8'(j - 4);
            e[9:8] = {(j == n + 3), ~x};
            chk("tx byte", e, u_usbrs_line_model.got_q[j]);
        end
        // One edge more than the bound: the byte is taken an edge later
        if (lat) chk("delay", 10'h001, 10'((u_usbrs_line_model.at_q[0]
            - t_first) <= 25.0 * (usbrs_pkg::MAX_DLY_SYNC32_CYC + 1)));
        u_usbrs_line_model.got_q.delete();
        u_usbrs_line_model.at_q.delete();
    endtask

    task automatic do_reset(input logic s, input logic e);
        int n;
        @(posedge clk);
        rst_n <= 1'b0;
        strap <= s;
        en <= e;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk_path(usbrs_pkg::ST_RESET, 1'b0, 1'b0);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge clk);
        chk_path(usbrs_pkg::ST_INIT, 1'b1, 1'b0);
        chk("charge only", 10'h001, 10'(bc));
        wait_leave(usbrs_pkg::ST_INIT, n);
        chk("init cycles", 10'(INIT), 10'(n));
        chk("charge only", 10'h000, 10'(bc));
        if (e) begin
            chk_path(usbrs_pkg::ST_DISC, 1'b1, 1'b0);
            @(negedge clk);
            chk_path(usbrs_pkg::ST_FSLS, 1'b1, 1'b0);
        end else begin
            ev(0);
            chk_path(usbrs_pkg::ST_DISC, 1'b1, 1'b0);
        end
        $display("Test reset done");
    endtask

    task automatic t_retime;
        ev(0);
        chk_path(usbrs_pkg::ST_HS, 1'b0, 1'b1);
        repeat (204) @(posedge clk);
        send_pkt(3, 1'b0, 8'h10);
        chk_pkt(3, 1'b0, 8'h10, 1'b1);
        @(posedge clk);
        slow <= 1'b1;
        send_pkt(5, 1'b1, 8'h40);
        chk_pkt(5, 1'b1, 8'h40, 1'b0);
        @(posedge clk);
        taken = 0;
        stall <= 1'b1;
        slow <= 1'b0;
        fork
            send_pkt(DEPTH + 4, 1'b0, 8'h80);
            begin
                while (rx_rdy !== 1'b0) @(negedge clk);
                repeat (4) @(negedge clk);
                chk("refused", 10'h000, 10'(rx_rdy));
                chk("filled", 10'h001, 10'(taken >= DEPTH));
                @(posedge clk);
                stall <= 1'b0;
            end
        join
        chk_pkt(DEPTH + 4, 1'b0, 8'h80, 1'b0);
        $display("Test retime done");
    endtask

    task automatic t_leave_hs;
        int n;
        ev(2);
        chk_path(usbrs_pkg::ST_FSLS, 1'b1, 1'b0);
        chk("rx ready", 10'h000, 10'(rx_rdy));
        ev(1);
        chk_path(usbrs_pkg::ST_HS, 1'b0, 1'b1);
        @(posedge clk);
        se0e <= 1'b1;
        repeat (SE0 - 4) @(posedge clk);
        se0e <= 1'b0;
        @(negedge clk);
        chk_path(usbrs_pkg::ST_HS, 1'b0, 1'b1);
        @(posedge clk);
        se0i <= 1'b1;
        @(negedge clk);
        wait_leave(usbrs_pkg::ST_HS, n);
        chk("se0 cycles", 10'(SE0), 10'(n));
        chk_path(usbrs_pkg::ST_FSLS, 1'b1, 1'b0);
        @(posedge clk);
        se0i <= 1'b0;
        en <= 1'b0;
        repeat (44) @(negedge clk);
        chk_path(usbrs_pkg::ST_DISC, 1'b1, 1'b0);
        @(posedge clk);
        en <= 1'b1;
        repeat (4) @(negedge clk);
        chk_path(usbrs_pkg::ST_FSLS, 1'b1, 1'b0);
        $display("Test leave high speed done");
    endtask

    task automatic t_detach;
        int n;
        do_reset(1'b1, 1'b0);
        @(posedge clk);
        en <= 1'b1;
        repeat (4) @(negedge clk);
        chk_path(usbrs_pkg::ST_FSLS, 1'b1, 1'b0);
        ev(0);
        ev(2);
        chk_path(usbrs_pkg::ST_DETACH, 1'b0, 1'b0);
        wait_leave(usbrs_pkg::ST_DETACH, n);
        chk("detach cycles", 10'(DET), 10'(n));
        chk_path(usbrs_pkg::ST_FSLS, 1'b1, 1'b0);
        $display("Test detach done");
    endtask

    initial begin
        {rst_n, en, strap, se0i, se0e, evt} = 8'h00;
        {rxv, rxl, rxe, stall, slow, rxd} = 13'h0000;
        do_reset(1'b0, 1'b1);
        t_retime();
        t_leave_hs();
        t_detach();
        final_report();
    end
endmodule

`default_nettype wire
